// >>> verilog/bps_cfg.svh
// offsets, field positions, reset values and data type codes of the preamble status bank
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH
//
// Notes on behaviour
// - data type codes in burst info bits 4..0
// - burst info bits 6 and 5 read zero
// - burst info bit 7 flags payload errors
// - burst info bits 12..8 pass through unchanged
// - stream number bits 15..13 are zero
// - burst length high byte register, read only
// - burst length low byte register, read only
// - page one reaches receiver buffer page
// - page two reaches transmitter buffer page
// - page defaults to control page; three reserved
// - page register answers 0x7f on every page
// - page applies to reads and writes alike
// - status registers hold receiver decoded preambles
// - burst length counts bits

// ----------------------------------------
// register offsets
// ----------------------------------------
`define BPS_ADDR_W 7
`define BPS_OFS_PC_HIGH 7'h29
`define BPS_OFS_PC_LOW 7'h2a
`define BPS_OFS_PD_HIGH 7'h2b
`define BPS_OFS_PD_LOW 7'h2c
`define BPS_OFS_PAGE 7'h7f

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define BPS_PAGE_MSB 1
`define BPS_PAGE_RESET 2'h0
`define BPS_PC_RESET 16'h0000
`define BPS_PD_RESET 16'h0000
`define BPS_PC_TYPE_MSB 4
`define BPS_PC_ZERO_HI 6
`define BPS_PC_ZERO_LO 5
`define BPS_PC_ERR_BIT 7
`define BPS_PC_DEP_MSB 12
`define BPS_PC_DEP_LSB 8
`define BPS_PC_STREAM_MSB 15
`define BPS_PC_STREAM_LSB 13
`define BPS_STREAM_NUM 3'h0
`define BPS_BYTE_ZERO 8'h00
`define BPS_ADDR_ZERO 7'h00

// ----------------------------------------
// data type codes
// ----------------------------------------
`define BPS_TYPE_RSVD_A 5'h02
`define BPS_TYPE_RSVD_B 5'h0a
`define BPS_TYPE_RSVD_FIRST 5'h10
`endif

// >>> verilog/bps_pkg.sv
// types shared by the preamble status bank
package bps_pkg;
  typedef enum logic [1:0] {
    BPS_PAGE_CTRL = 2'h0,
    BPS_PAGE_RXBUF = 2'h1,
    BPS_PAGE_TXBUF = 2'h2,
    BPS_PAGE_RSVD = 2'h3
  } bps_page_t;
endpackage : bps_pkg

// >>> verilog/bps_pre_if.sv
// captured preamble values passed from the capture stage to the register bank
`timescale 1ns/1ps
interface bps_pre_if;
  logic [15:0] burst_info;
  logic [15:0] burst_length;
  logic payload_err;
  logic type_reserved;
  modport cap (output burst_info, output burst_length, output payload_err, output type_reserved);
  modport bank (input burst_info, input burst_length, input payload_err, input type_reserved);
endinterface : bps_pre_if

// >>> verilog/bps_capture.sv
// latches the preamble words decoded by the receiver
`timescale 1ns/1ps
`include "bps_cfg.svh"
module bps_capture (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // decoder side
  input wire logic dec_valid,
  input wire logic [15:0] dec_pc,
  input wire logic [15:0] dec_pd,
  // captured values
  bps_pre_if.cap pre
);
  logic [15:0] pc_ff;
  logic [15:0] pd_ff;
  logic [15:0] nxt_pc;

  // codes with no defined stream type
  function automatic logic is_reserved(input logic [4:0] code);
    is_reserved = (code == `BPS_TYPE_RSVD_A) || (code == `BPS_TYPE_RSVD_B) ||
                  (code >= `BPS_TYPE_RSVD_FIRST);
  endfunction : is_reserved

  always_comb begin
    nxt_pc = dec_pc;
    nxt_pc[`BPS_PC_ZERO_HI:`BPS_PC_ZERO_LO] = 2'h0;
    nxt_pc[`BPS_PC_STREAM_MSB:`BPS_PC_STREAM_LSB] = `BPS_STREAM_NUM;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff <= `BPS_PC_RESET;
    end else if (dec_valid) begin
      pc_ff <= nxt_pc;
    end
  end

  // burst length is a bit count, held as decoded
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pd_ff <= `BPS_PD_RESET;
    end else if (dec_valid) begin
      pd_ff <= dec_pd;
    end
  end

  assign pre.burst_info = pc_ff;
  assign pre.burst_length = pd_ff;
  assign pre.payload_err = pc_ff[`BPS_PC_ERR_BIT];
  assign pre.type_reserved = is_reserved(pc_ff[`BPS_PC_TYPE_MSB:0]);
endmodule : bps_capture

// >>> verilog/bps_bank.sv
// preamble status registers and page selector behind the serial host interface
`timescale 1ns/1ps
`include "bps_cfg.svh"
module bps_bank (
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // decoded preambles from the receiver
  input wire logic DEC_VALID,
  input wire logic [15:0] DEC_PC,
  input wire logic [15:0] DEC_PD,
  // host register access
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic [6:0] HOST_ADDR,
  input wire logic [7:0] HOST_WDATA,
  output logic [7:0] HOST_RDATA,
  output logic HOST_RVALID,
  // buffer page access
  output logic RXB_WR,
  output logic RXB_RD,
  output logic TXB_WR,
  output logic TXB_RD,
  output logic [6:0] BUF_ADDR,
  output logic [7:0] BUF_WDATA,
  input wire logic [7:0] RXB_RDATA,
  input wire logic [7:0] TXB_RDATA,
  // status
  output bps_pkg::bps_page_t PAGE,
  output logic PAYLOAD_ERR,
  output logic TYPE_RESERVED
);
  import bps_pkg::*;

  bps_pre_if pre ();

  bps_capture u_capture (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .dec_valid(DEC_VALID),
    .dec_pc(DEC_PC),
    .dec_pd(DEC_PD),
    .pre(pre.cap)
  );

  // ----------------------------------------
  // page selector
  // ----------------------------------------
  bps_page_t page_ff;
  logic page_hit;
  logic buf_access;

  // the selector is seen at one address on all pages so the host never gets stuck
  assign page_hit = (HOST_ADDR == `BPS_OFS_PAGE);
  assign buf_access = !page_hit && (page_ff == BPS_PAGE_RXBUF || page_ff == BPS_PAGE_TXBUF);

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      page_ff <= BPS_PAGE_CTRL;
    end else if (HOST_WR && page_hit) begin
      page_ff <= bps_page_t'(HOST_WDATA[`BPS_PAGE_MSB:0]);
    end
  end

  // ----------------------------------------
  // buffer page forwarding
  // ----------------------------------------
  logic rxb_wr_ff;
  logic rxb_rd_ff;
  logic txb_wr_ff;
  logic txb_rd_ff;
  logic [6:0] buf_addr_ff;
  logic [7:0] buf_wdata_ff;

  // one registered strobe per host access; selected page steers reads and writes alike
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rxb_wr_ff <= 1'b0;
      rxb_rd_ff <= 1'b0;
      txb_wr_ff <= 1'b0;
      txb_rd_ff <= 1'b0;
    end else begin
      rxb_wr_ff <= HOST_WR && buf_access && page_ff == BPS_PAGE_RXBUF;
      rxb_rd_ff <= HOST_RD && buf_access && page_ff == BPS_PAGE_RXBUF;
      txb_wr_ff <= HOST_WR && buf_access && page_ff == BPS_PAGE_TXBUF;
      txb_rd_ff <= HOST_RD && buf_access && page_ff == BPS_PAGE_TXBUF;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      buf_addr_ff <= `BPS_ADDR_ZERO;
      buf_wdata_ff <= `BPS_BYTE_ZERO;
    end else if ((HOST_WR || HOST_RD) && buf_access) begin
      buf_addr_ff <= HOST_ADDR;
      buf_wdata_ff <= HOST_WDATA;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] nxt_local;
  logic local_rd_ff;
  logic [7:0] local_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic rxb_sel_ff;
  logic txb_sel_ff;

  // page zero decode; status registers have no write path at all
  always_comb begin
    nxt_local = `BPS_BYTE_ZERO;
    if (page_hit) begin
      nxt_local = {6'h00, page_ff};
    end else if (page_ff != BPS_PAGE_CTRL) begin
      nxt_local = `BPS_BYTE_ZERO;
    end else if (HOST_ADDR == `BPS_OFS_PC_HIGH) begin
      nxt_local = pre.burst_info[15:8];
    end else if (HOST_ADDR == `BPS_OFS_PC_LOW) begin
      nxt_local = pre.burst_info[7:0];
    end else if (HOST_ADDR == `BPS_OFS_PD_HIGH) begin
      nxt_local = pre.burst_length[15:8];
    end else if (HOST_ADDR == `BPS_OFS_PD_LOW) begin
      nxt_local = pre.burst_length[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      local_rd_ff <= 1'b0;
      local_ff <= `BPS_BYTE_ZERO;
    end else begin
      local_rd_ff <= HOST_RD && !buf_access;
      if (HOST_RD && !buf_access) begin
        local_ff <= nxt_local;
      end
    end
  end

  // buffers answer one cycle after their strobe, so buffer reads land a cycle later
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rxb_sel_ff <= 1'b0;
      txb_sel_ff <= 1'b0;
    end else begin
      rxb_sel_ff <= rxb_rd_ff;
      txb_sel_ff <= txb_rd_ff;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_ff <= `BPS_BYTE_ZERO;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= local_rd_ff || rxb_sel_ff || txb_sel_ff;
      if (rxb_sel_ff) begin
        rdata_ff <= RXB_RDATA;
      end else if (txb_sel_ff) begin
        rdata_ff <= TXB_RDATA;
      end else if (local_rd_ff) begin
        rdata_ff <= local_ff;
      end
    end
  end

  assign HOST_RDATA = rdata_ff;
  assign HOST_RVALID = rvalid_ff;
  assign RXB_WR = rxb_wr_ff;
  assign RXB_RD = rxb_rd_ff;
  assign TXB_WR = txb_wr_ff;
  assign TXB_RD = txb_rd_ff;
  assign BUF_ADDR = buf_addr_ff;
  assign BUF_WDATA = buf_wdata_ff;
  assign PAGE = page_ff;
  assign PAYLOAD_ERR = pre.payload_err;
  assign TYPE_RESERVED = pre.type_reserved;
endmodule : bps_bank

// >>> test/bps_bank_sva.sv
// port-level checks of the preamble status bank
`timescale 1ns/1ps
module bps_bank_sva (
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // requests
  input wire logic DEC_VALID,
  input wire logic [15:0] DEC_PC,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic [6:0] HOST_ADDR,
  input wire logic [7:0] HOST_WDATA,
  // answers
  input wire logic [7:0] HOST_RDATA,
  input wire logic HOST_RVALID,
  input wire logic RXB_WR,
  input wire logic RXB_RD,
  input wire logic TXB_WR,
  input wire logic TXB_RD,
  input wire logic [6:0] BUF_ADDR,
  input wire logic [7:0] BUF_WDATA,
  input wire logic [7:0] RXB_RDATA,
  input wire logic [7:0] TXB_RDATA,
  input wire bps_pkg::bps_page_t PAGE,
  input wire logic PAYLOAD_ERR,
  input wire logic TYPE_RESERVED
);
  import bps_pkg::*;
  logic rsv;
  logic any_buf;
  assign rsv = DEC_PC[4] | (DEC_PC[4:0] == 5'h02) | (DEC_PC[4:0] == 5'h0a);
  assign any_buf = RXB_WR | RXB_RD | TXB_WR | TXB_RD;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  a_page_write: assert property (HOST_WR && HOST_ADDR == 7'h7f |=> PAGE == ($past(HOST_WDATA) & 8'h03))
    else $error("page write not applied");
  a_page_read: assert property (HOST_RD && HOST_ADDR == 7'h7f |-> ##2 HOST_RVALID && HOST_RDATA[7:2] == 6'h00)
    else $error("page read late or upper bits set");
  a_rx_route: assert property (HOST_RD && PAGE == BPS_PAGE_RXBUF && HOST_ADDR != 7'h7f
    |=> RXB_RD && !TXB_RD && BUF_ADDR == $past(HOST_ADDR)) else $error("rx page read misrouted");
  a_tx_route: assert property (HOST_WR && PAGE == BPS_PAGE_TXBUF && HOST_ADDR != 7'h7f
    |=> TXB_WR && !RXB_WR && BUF_WDATA == $past(HOST_WDATA)) else $error("tx page write misrouted");
  a_ctrl_no_buf: assert property ((HOST_WR || HOST_RD) && (PAGE == BPS_PAGE_CTRL || PAGE == BPS_PAGE_RSVD)
    |=> !any_buf) else $error("buffer strobe on page 0 or 3");
  a_err_flag: assert property (DEC_VALID |=> PAYLOAD_ERR == $past(DEC_PC[7]))
    else $error("error flag not captured");
  a_type_code: assert property (DEC_VALID |=> TYPE_RESERVED == $past(rsv))
    else $error("reserved type decode wrong");
  a_status_hold: assert property (!DEC_VALID |=> $stable(PAYLOAD_ERR) && $stable(TYPE_RESERVED))
    else $error("status changed without decode");
  a_rx_answer: assert property (RXB_RD |-> ##2 HOST_RVALID && HOST_RDATA == $past(RXB_RDATA))
    else $error("rx buffer answer late or wrong");
  a_tx_answer: assert property (TXB_RD |-> ##2 HOST_RVALID && HOST_RDATA == $past(TXB_RDATA))
    else $error("tx buffer answer late or wrong");
endmodule : bps_bank_sva
bind bps_bank bps_bank_sva chk (.CLOCK(CLOCK), .ARST_N(ARST_N), .DEC_VALID(DEC_VALID), .DEC_PC(DEC_PC),
  .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA),
  .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID), .RXB_WR(RXB_WR), .RXB_RD(RXB_RD), .TXB_WR(TXB_WR),
  .TXB_RD(TXB_RD), .BUF_ADDR(BUF_ADDR), .BUF_WDATA(BUF_WDATA), .RXB_RDATA(RXB_RDATA), .TXB_RDATA(TXB_RDATA),
  .PAGE(PAGE), .PAYLOAD_ERR(PAYLOAD_ERR),
  .TYPE_RESERVED(TYPE_RESERVED));

// >>> test/bps_bank_tb.sv
// self-checking bench for the preamble status bank
`timescale 1ns/1ps
module bps_bank_tb;
  import bps_pkg::*;
  logic CLOCK = 1'b0, ARST_N = 1'b0, DEC_VALID = 1'b0, HOST_WR = 1'b0, HOST_RD = 1'b0;
  logic [15:0] DEC_PC = 16'h0000, DEC_PD = 16'h0000;
  logic [6:0] HOST_ADDR = 7'h00, BUF_ADDR;
  logic [7:0] HOST_WDATA = 8'h00, RXB_RDATA = 8'h00, TXB_RDATA = 8'h00, HOST_RDATA, BUF_WDATA;
  logic HOST_RVALID, RXB_WR, RXB_RD, TXB_WR, TXB_RD, PAYLOAD_ERR, TYPE_RESERVED;
  logic [7:0] rx_word = 8'h00, tx_word = 8'h00;
  bps_page_t PAGE;
  int n_fail = 0, compares = 0, cycles = 0;
  always #2 CLOCK = ~CLOCK;
  bps_bank uut (.CLOCK(CLOCK), .ARST_N(ARST_N), .DEC_VALID(DEC_VALID), .DEC_PC(DEC_PC), .DEC_PD(DEC_PD),
    .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA),
    .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID), .RXB_WR(RXB_WR), .RXB_RD(RXB_RD), .TXB_WR(TXB_WR),
    .TXB_RD(TXB_RD), .BUF_ADDR(BUF_ADDR), .BUF_WDATA(BUF_WDATA), .RXB_RDATA(RXB_RDATA),
    .TXB_RDATA(TXB_RDATA), .PAGE(PAGE), .PAYLOAD_ERR(PAYLOAD_ERR), .TYPE_RESERVED(TYPE_RESERVED));
  // ----
  // host and decoder tasks
  // ----
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    HOST_WR <= 1'b1;
    HOST_ADDR <= a;
    HOST_WDATA <= d;
    @(posedge CLOCK);
    HOST_WR <= 1'b0;
  endtask : wr
  // answer latency differs by page, so wait on HOST_RVALID, bounded
  task rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    @(posedge CLOCK);
    HOST_RD <= 1'b1;
    HOST_ADDR <= a;
    @(posedge CLOCK);
    HOST_RD <= 1'b0;
    q = 8'hxx;
    for (int i = 0; i < 5; i++) begin
      @(negedge CLOCK);
      if (HOST_RVALID === 1'b1) begin
        q = HOST_RDATA;
        break;
      end
    end
    check(q, e);
  endtask : rdc
  task dec(input logic [15:0] pc, input logic [15:0] pd);
    @(posedge CLOCK);
    DEC_VALID <= 1'b1;
    DEC_PC <= pc;
    DEC_PD <= pd;
    @(posedge CLOCK);
    DEC_VALID <= 1'b0;
    @(negedge CLOCK);
  endtask : dec
  // buffers answer only in the cycle after their read strobe
  always @(posedge CLOCK) begin
    RXB_RDATA <= RXB_RD ? rx_word : 8'h00;
    TXB_RDATA <= TXB_RD ? tx_word : 8'h00;
  end
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop;
    end
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (8) @(posedge CLOCK);
    ARST_N <= 1'b1;
    rdc(7'h7f, 8'h00);
    check(PAGE, BPS_PAGE_CTRL);
    $display("test reset done");
    dec(16'hffff, 16'h1234);
    check(PAYLOAD_ERR, 1'b1);
    rdc(7'h29, 8'h1f);
    rdc(7'h2a, 8'h9f);
    rdc(7'h2b, 8'h12);
    rdc(7'h2c, 8'h34);
    wr(7'h2c, 8'hff);
    rdc(7'h2c, 8'h34);
    $display("test preamble done");
    for (int c = 0; c < 32; c++) begin
      dec({3'h5, 5'(c), 3'h3, 5'(c)}, 16'(c * 8));
      check(TYPE_RESERVED, c == 2 || c == 10 || c > 15);
      rdc(7'h2a, {3'h0, 5'(c)});
      rdc(7'h29, {3'h0, 5'(c)});
    end
    $display("test type codes done");
    wr(7'h7f, 8'hff);
    rdc(7'h7f, 8'h03);
    rdc(7'h2c, 8'h00);
    wr(7'h7f, 8'h01);
    rx_word = 8'h5a;
    rdc(7'h05, 8'h5a);
    wr(7'h7f, 8'h02);
    tx_word = 8'ha5;
    rdc(7'h05, 8'ha5);
    wr(7'h09, 8'h3c);
    wr(7'h7f, 8'h00);
    rdc(7'h2c, 8'hf8);
    $display("test pages done");
    wr(7'h7f, 8'h02);
    @(posedge CLOCK);
    ARST_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    ARST_N <= 1'b1;
    check(TYPE_RESERVED, 1'b0);
    rdc(7'h7f, 8'h00);
    rdc(7'h2c, 8'h00);
    $display("test second reset done");
    report_and_stop;
  end
endmodule : bps_bank_tb
